/* File: ssc_pkg.sv */
// constants, encodings and the parity helper for the serial status/control block
// assumes a single 250 MHz clock domain and a plain register port
`default_nettype none
package ssc_pkg;
    // register addresses on the plain register port
    localparam logic [1:0] ADDR_STATUS = 2'h0;
    localparam logic [1:0] ADDR_DATA = 2'h1;
    localparam logic [1:0] ADDR_CTRL1 = 2'h2;
    localparam logic [1:0] ADDR_CTRL2 = 2'h3;
    // reset values
    localparam logic [7:0] STATUS_RESET = 8'hC0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // serial_status bit positions
    localparam int ST_TX_EMPTY = 7;
    localparam int ST_TX_DONE = 6;
    localparam int ST_RX_FULL = 5;
    localparam int ST_IDLE = 4;
    localparam int ST_OVERRUN = 3;
    localparam int ST_NOISE = 2;
    localparam int ST_FRAMING = 1;
    localparam int ST_PARITY = 0;
    // serial_control_one bit positions
    localparam int CR1_RX_NINTH = 7;
    localparam int CR1_TX_NINTH = 6;
    localparam int CR1_LP_STOP = 5;
    localparam int CR1_NINE = 4;
    localparam int CR1_WAKE_ADDR = 3;
    localparam int CR1_PARITY_ON = 2;
    localparam int CR1_PARITY_ODD = 1;
    localparam int CR1_PARITY_IRQ = 0;
    // serial_control_two bit positions
    localparam int CR2_TX_EMPTY_IRQ = 7;
    localparam int CR2_TX_DONE_IRQ = 6;
    localparam int CR2_RX_IRQ = 5;
    localparam int CR2_IDLE_IRQ = 4;
    localparam int CR2_TX_ON = 3;
    localparam int CR2_RX_ON = 2;
    localparam int CR2_RX_MUTE = 1;
    localparam int CR2_SEND_BREAK = 0;
    // data bit counts and whole frame lengths in bit times
    localparam logic [3:0] BITS_EIGHT = 4'h8;
    localparam logic [3:0] BITS_NINE = 4'h9;
    localparam logic [3:0] FRAME_EIGHT = 4'hA;
    localparam logic [3:0] FRAME_NINE = 4'hB;
    localparam logic [3:0] CNT_ONE = 4'h1;
    // parity coverage masks
    localparam logic [8:0] PMASK_TX8 = 9'h07F;
    localparam logic [8:0] PMASK_TX9 = 9'h0FF;
    localparam logic [8:0] PMASK_RX8 = 9'h0FF;
    localparam logic [8:0] PMASK_RX9 = 9'h1FF;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h1, TX_START = 4'h2, TX_DATA = 4'h4, TX_STOP = 4'h8
    } ssc_tx_e;
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8
    } ssc_rx_e;
    typedef enum logic [2:0] {
        KIND_DATA = 3'h1, KIND_PREAMBLE = 3'h2, KIND_BREAK = 3'h4
    } ssc_kind_e;

    // parity of the masked bits, inverted for odd parity
    function automatic logic ssc_par(input logic [8:0] v, input logic [8:0] m,
                                     input logic odd);
        ssc_par = (^(v & m)) ^ odd;
    endfunction
endpackage
`default_nettype wire

/* File: ssc_bit_timer.sv */
// bit-time prescaler: one tick per bit time, restartable at half a bit
// assumes run is low whenever the counter must freeze
`default_nettype none
module ssc_bit_timer #(parameter int CYCLES = 16) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic restart,
    output logic tick
);
    localparam int W = $clog2(CYCLES);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);
    localparam logic [W-1:0] HALF = W'(CYCLES / 2);
    logic [W-1:0] cnt;

    // tick on the last count of each bit time
    assign tick = run && (cnt == LAST);

    // counter holds while stopped so a frozen frame resumes in place
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cnt <= '0;
        end else if (restart) begin
            cnt <= HALF;
        end else if (run) begin
            cnt <= tick ? '0 : cnt + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: ssc_top.sv */
// serial interface status, control and interrupt logic with its bit engines
// assumes register strobes synchronous to mclk and a sampled receive line
`default_nettype none
// What this block does
// - in wait mode keep running; enabled, unmasked events raise a wake request
// - in halt mode freeze engines and registers; no interrupt or wake
// - all events share one request, gated by enables and the cpu mask
// - status resets to C0h and ignores software writes
// - buffer-empty flag sets on transfer to shifter; status then data write clears
// - no transfer while buffer-empty flag is still set
// - transmit-done flag sets after data frames only; status then data write clears
// - receive-full sets on delivery; status then data read clears
// - idle flag sets on idle line, rearmed only by a new receive-full
// - overrun keeps old holding data and raises via receive enable
// - noise flag sets with delivery, no own interrupt
// - framing flag on bad stop or break; overrun wins over it
// - parity flag sets on failed check; status read then data access clears
// - ninth received bit stored, ninth sent bit taken from control one
// - low-power stop halts prescalers and outputs after current byte
// - word length selects eight or nine data bits; not changed mid-frame
// - wake method: idle line or address mark
// - parity replaces word msb and is checked; change applies next byte
// - parity select even or odd, applied from next byte
// - parity interrupt enable gates the parity flag onto the request
// - receive enable requests on overrun or receive-full
// - one bit time passes after transmit enable before sending
// - send-break set then cleared sends one break word after current word
// - mute set by software, cleared by hardware on selected wake
module ssc_top import ssc_pkg::*; #(parameter int BIT_CYCLES = 16) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic cpuIntMask,
    input wire logic waitMode,
    input wire logic haltMode,
    output logic irqReq,
    output logic wakeReq,
    input wire logic rxLine,
    output logic txLine,
    output logic txLineEn
);
    logic [6:0] ctrlOne;
    logic [7:0] ctrlTwo;
    logic rxNinth;
    logic txEmpty, txDone, rxFull, idleFlag, overrun, noiseFlag, framingFlag, parityErr;
    logic [7:0] status, snap, txHolding, rxHolding;
    logic seen, seenByRead;
    logic statusAcc, dataRd, dataWr, clrRx, clrTx, clrPe;
    ssc_tx_e txState;
    ssc_rx_e rxState;
    ssc_kind_e txKind;
    logic txTick, txRun, txReady, txOnPrev, brkPrev, prePend, brkPend;
    logic txStart, txLoad, tcSet;
    logic [8:0] txData, txShift;
    logic [3:0] txCnt;
    logic rxTick, rxRun, rxStartDet, rxLinePrev, rxNoise, rxFrErr;
    logic rxNine, rxParOn, rxParOdd, idleArmed;
    logic [8:0] rxShift, rxWord;
    logic [3:0] rxCnt, idleCnt;
    logic rxDone, addrWake, accept, rxSet, ovrSet, idleEv, idleSet, rxParBad;
    logic lpStop, nine, muteOn;

    assign lpStop = ctrlOne[CR1_LP_STOP];
    assign nine = ctrlOne[CR1_NINE];
    assign muteOn = ctrlTwo[CR2_RX_MUTE];
    assign status = {txEmpty, txDone, rxFull, idleFlag, overrun, noiseFlag,
                     framingFlag, parityErr};

    // register port decode; writes and clearing accesses are ignored while halted, plain reads still return data
    assign statusAcc = (regRd || regWr) && regAddr == ADDR_STATUS && !haltMode;
    assign dataRd = regRd && regAddr == ADDR_DATA && !haltMode;
    assign dataWr = regWr && regAddr == ADDR_DATA && !haltMode;

    // two-step clear: remember which flags were seen at the status access
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            seen <= 1'b0;
            seenByRead <= 1'b0;
            snap <= 8'h00;
        end else if (statusAcc) begin
            seen <= 1'b1;
            seenByRead <= regRd;
            snap <= status;
        end else if (dataRd || dataWr) begin
            seen <= 1'b0;
            seenByRead <= 1'b0;
        end
    end
    assign clrRx = seen && dataRd;
    assign clrTx = seen && dataWr;
    assign clrPe = seen && seenByRead && (dataRd || dataWr) && snap[ST_PARITY];

    // control registers; hardware wake clears mute unless software writes either control register
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ctrlOne <= CTRL_RESET[6:0];
            ctrlTwo <= CTRL_RESET;
        end else if (regWr && !haltMode && regAddr == ADDR_CTRL1) begin
            ctrlOne <= regWrData[6:0];
        end else if (regWr && !haltMode && regAddr == ADDR_CTRL2) begin
            ctrlTwo <= regWrData;
        end else if (addrWake || (idleEv && muteOn && !ctrlOne[CR1_WAKE_ADDR])) begin
            ctrlTwo[CR2_RX_MUTE] <= 1'b0;
        end
    end

    // transmit holding register
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            txHolding <= 8'h00;
        end else if (dataWr) begin
            txHolding <= regWrData;
        end
    end

    // read data valid in the cycle after the read strobe only
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            regRdData <= 8'h00;
        end else if (regRd) begin
            unique case (regAddr)
                ADDR_STATUS: regRdData <= status;
                ADDR_DATA: regRdData <= rxHolding;
                ADDR_CTRL1: regRdData <= {rxNinth, ctrlOne};
                ADDR_CTRL2: regRdData <= ctrlTwo;
            endcase
        end else begin
            regRdData <= 8'h00;
        end
    end

    // shared request and wake, nothing while halted
    always_comb begin
        irqReq = ((txEmpty && ctrlTwo[CR2_TX_EMPTY_IRQ])
                 || (txDone && ctrlTwo[CR2_TX_DONE_IRQ])
                 || ((rxFull || overrun) && ctrlTwo[CR2_RX_IRQ])
                 || (idleFlag && ctrlTwo[CR2_IDLE_IRQ])
                 || (parityErr && ctrlOne[CR1_PARITY_IRQ]))
                 && !cpuIntMask && !haltMode;
        wakeReq = irqReq && waitMode;
    end

    // transmit prescaler runs while enabled or busy, stops in halt or in low power when idle
    assign txRun = !haltMode && (ctrlTwo[CR2_TX_ON] || txState != TX_IDLE)
                   && !(lpStop && txState == TX_IDLE);
    ssc_bit_timer #(.CYCLES(BIT_CYCLES)) u_txTimer (
        .mclk(mclk),
        .rst_b(rst_b),
        .run(txRun),
        .restart(1'b0),
        .tick(txTick)
    );

    // frame selection: break, then preamble, then data only when flag is clear
    assign txStart = txState == TX_IDLE && txTick && txReady
                     && (brkPend || prePend || !txEmpty);
    assign txLoad = txStart && !brkPend && !prePend && !txEmpty;
    assign tcSet = txState == TX_STOP && txTick && txKind == KIND_DATA;
    always_comb begin
        txData = {ctrlOne[CR1_TX_NINTH], txHolding};
        if (ctrlOne[CR1_PARITY_ON]) begin
            if (nine) begin
                txData[8] = ssc_par(txData, PMASK_TX9, ctrlOne[CR1_PARITY_ODD]);
            end else begin
                txData[7] = ssc_par(txData, PMASK_TX8, ctrlOne[CR1_PARITY_ODD]);
            end
        end
    end

    // enable delay, preamble and break requests
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            txReady <= 1'b0;
            txOnPrev <= 1'b0;
            brkPrev <= 1'b0;
            prePend <= 1'b0;
            brkPend <= 1'b0;
        end else if (!haltMode) begin
            txOnPrev <= ctrlTwo[CR2_TX_ON];
            brkPrev <= ctrlTwo[CR2_SEND_BREAK];
            if (!ctrlTwo[CR2_TX_ON]) begin
                txReady <= 1'b0;
            end else if (txTick) begin
                txReady <= 1'b1;
            end
            if (ctrlTwo[CR2_TX_ON] && !txOnPrev) begin
                prePend <= 1'b1;
            end else if (txStart && !brkPend) begin
                prePend <= 1'b0;
            end
            if (brkPrev && !ctrlTwo[CR2_SEND_BREAK]) begin
                brkPend <= 1'b1;
            end else if (txStart) begin
                brkPend <= 1'b0;
            end
        end
    end

    // transmit frame engine, format latched at frame start
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            txState <= TX_IDLE;
            txKind <= KIND_DATA;
            txShift <= 9'h000;
            txCnt <= 4'h0;
            txLine <= 1'b1;
        end else if (txTick) begin
            unique case (txState)
                TX_IDLE: if (txStart) begin
                    txState <= TX_START;
                    txCnt <= nine ? BITS_NINE : BITS_EIGHT;
                    if (brkPend) begin
                        txKind <= KIND_BREAK;
                        txShift <= 9'h000;
                        txLine <= 1'b0;
                    end else if (prePend) begin
                        txKind <= KIND_PREAMBLE;
                        txShift <= 9'h1FF;
                    end else begin
                        txKind <= KIND_DATA;
                        txShift <= txData;
                        txLine <= 1'b0;
                    end
                end
                TX_START, TX_DATA: begin
                    if (txCnt == 4'h0) begin
                        txState <= TX_STOP;
                        txLine <= txKind != KIND_BREAK;
                    end else begin
                        txState <= TX_DATA;
                        txLine <= txShift[0];
                        txShift <= {1'b0, txShift[8:1]};
                        txCnt <= txCnt - CNT_ONE;
                    end
                end
                TX_STOP: begin
                    txState <= TX_IDLE;
                    txLine <= 1'b1;
                end
            endcase
        end
    end
    assign txLineEn = (ctrlTwo[CR2_TX_ON] || txState != TX_IDLE)
                      && !(lpStop && txState == TX_IDLE);

    // receive prescaler, restarted half a bit into the start bit
    assign rxRun = !haltMode && ctrlTwo[CR2_RX_ON] && !(lpStop && rxState == RX_IDLE);
    assign rxStartDet = rxState == RX_IDLE && rxRun && !rxLine;
    ssc_bit_timer #(.CYCLES(BIT_CYCLES)) u_rxTimer (
        .mclk(mclk),
        .rst_b(rst_b),
        .run(rxRun),
        .restart(rxStartDet),
        .tick(rxTick)
    );

    // receive frame engine; noise when the line moved just before the sample
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rxState <= RX_IDLE;
            rxShift <= 9'h000;
            rxCnt <= 4'h0;
            rxNoise <= 1'b0;
            rxNine <= 1'b0;
            rxParOn <= 1'b0;
            rxParOdd <= 1'b0;
            rxLinePrev <= 1'b1;
        end else if (!haltMode) begin
            rxLinePrev <= rxLine;
            if (rxStartDet) begin
                rxState <= RX_START;
                rxNoise <= 1'b0;
                rxNine <= nine;
                rxParOn <= ctrlOne[CR1_PARITY_ON];
                rxParOdd <= ctrlOne[CR1_PARITY_ODD];
            end else if (rxTick && rxState != RX_IDLE) begin
                rxNoise <= rxNoise || (rxLine != rxLinePrev);
                unique case (rxState)
                    RX_START: begin
                        rxState <= rxLine ? RX_IDLE : RX_DATA;
                        rxCnt <= rxNine ? BITS_NINE : BITS_EIGHT;
                    end
                    RX_DATA: begin
                        rxShift <= {rxLine, rxShift[8:1]};
                        rxCnt <= rxCnt - CNT_ONE;
                        if (rxCnt == CNT_ONE) begin
                            rxState <= RX_STOP;
                        end
                    end
                    default: begin
                        rxState <= RX_IDLE;
                    end
                endcase
            end
        end
    end

    // completed word and its checks
    assign rxDone = rxState == RX_STOP && rxTick;
    assign rxWord = rxNine ? rxShift : {1'b0, rxShift[8:1]};
    assign rxParBad = rxParOn && ssc_par(rxWord, rxNine ? PMASK_RX9 : PMASK_RX8, rxParOdd);
    assign addrWake = rxDone && muteOn && ctrlOne[CR1_WAKE_ADDR]
                      && (rxNine ? rxWord[8] : rxWord[7]);
    assign accept = !muteOn || addrWake;
    assign rxSet = rxDone && accept && !rxFull;
    assign ovrSet = rxDone && accept && rxFull;
    always_comb begin
        rxFrErr = !rxLine;
    end

    // idle line: a whole frame time of high line while idle
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            idleCnt <= 4'h0;
        end else if (rxState != RX_IDLE || (rxTick && !rxLine)) begin
            idleCnt <= 4'h0;
        end else if (rxTick && !idleEv) begin
            idleCnt <= idleCnt + CNT_ONE;
        end
    end
    assign idleEv = rxState == RX_IDLE && rxTick && rxLine
                    && idleCnt == (nine ? FRAME_NINE : FRAME_EIGHT) - CNT_ONE;
    assign idleSet = idleEv && !muteOn && idleArmed;

    // idle rearms only after a new receive-full
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            idleArmed <= 1'b0;
        end else if (rxSet) begin
            idleArmed <= 1'b1;
        end else if (idleSet) begin
            idleArmed <= 1'b0;
        end
    end

    // received data and ninth bit, old data kept on overrun
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rxHolding <= 8'h00;
            rxNinth <= 1'b0;
        end else if (rxSet) begin
            rxHolding <= rxWord[7:0];
            if (rxNine) begin
                rxNinth <= rxWord[8];
            end
        end
    end

    // status flags: a set in the clearing cycle wins
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            {txEmpty, txDone, rxFull, idleFlag} <= STATUS_RESET[7:4];
            {overrun, noiseFlag, framingFlag, parityErr} <= STATUS_RESET[3:0];
        end else begin
            txEmpty <= txLoad || (txEmpty && !(clrTx && snap[ST_TX_EMPTY]));
            txDone <= tcSet || (txDone && !(clrTx && snap[ST_TX_DONE]));
            rxFull <= rxSet || (rxFull && !(clrRx && snap[ST_RX_FULL]));
            idleFlag <= idleSet || (idleFlag && !(clrRx && snap[ST_IDLE]));
            overrun <= ovrSet || (overrun && !(clrRx && snap[ST_OVERRUN]));
            noiseFlag <= (rxSet && rxNoise)
                         || (noiseFlag && !(clrRx && snap[ST_NOISE]));
            framingFlag <= (rxSet && rxFrErr)
                           || (framingFlag && !(clrRx && snap[ST_FRAMING]));
            parityErr <= (rxSet && rxParBad) || (parityErr && !clrPe);
        end
    end

    // checks
    sequence s_full_seen;
        regRd && regAddr == ADDR_STATUS && rxFull && !haltMode;
    endsequence
    sequence s_data_read;
        regRd && regAddr == ADDR_DATA && !haltMode && !rxSet && !regWr;
    endsequence
    property p_reset_status;
        @(posedge mclk) $rose(rst_b) |-> status == STATUS_RESET;
    endproperty
    a_reset_status: assert property (p_reset_status) else $error("status reset value");
    property p_halt_quiet;
        @(posedge mclk) disable iff (!rst_b) haltMode |-> !irqReq && !wakeReq;
    endproperty
    a_halt_quiet: assert property (p_halt_quiet) else $error("request in halt");
    property p_halt_freeze;
        @(posedge mclk) disable iff (!rst_b)
            haltMode ##1 haltMode |-> $stable(status) && $stable(txLine);
    endproperty
    a_halt_freeze: assert property (p_halt_freeze) else $error("state moved in halt");
    property p_mask_gate;
        @(posedge mclk) disable iff (!rst_b) cpuIntMask |-> !irqReq;
    endproperty
    a_mask_gate: assert property (p_mask_gate) else $error("request while masked");
    property p_overrun_irq;
        @(posedge mclk) disable iff (!rst_b)
            overrun && ctrlTwo[CR2_RX_IRQ] && !cpuIntMask && !haltMode |-> irqReq
                && (wakeReq == waitMode);
    endproperty
    a_overrun_irq: assert property (p_overrun_irq) else $error("overrun not requested");
    property p_no_load_empty;
        @(posedge mclk) disable iff (!rst_b) txLoad |-> !txEmpty ##1 txEmpty;
    endproperty
    a_no_load_empty: assert property (p_no_load_empty) else $error("bad transfer");
    property p_tc_data_only;
        @(posedge mclk) disable iff (!rst_b)
            $rose(txDone) |-> $past(txKind) == KIND_DATA && txState == TX_IDLE;
    endproperty
    a_tc_data_only: assert property (p_tc_data_only) else $error("done after non-data");
    property p_full_clear;
        @(posedge mclk) disable iff (!rst_b) s_full_seen ##1 s_data_read |=> !rxFull;
    endproperty
    a_full_clear: assert property (p_full_clear) else $error("receive-full not cleared");
    property p_ninth_store;
        @(posedge mclk) disable iff (!rst_b)
            rxSet && rxNine |=> rxNinth == $past(rxWord[8]) && rxFull;
    endproperty
    a_ninth_store: assert property (p_ninth_store) else $error("ninth bit lost");
    property p_overrun_keeps;
        @(posedge mclk) disable iff (!rst_b) ovrSet |=> $stable(rxHolding) && overrun;
    endproperty
    a_overrun_keeps: assert property (p_overrun_keeps) else $error("overrun data");
endmodule
`default_nettype wire

/* File: ssc_remote.sv */
// remote serial end: sends 8N1 frames and decodes frames seen on the transmit line
// assumes the line idles high and BC clocks per bit
`default_nettype none
module ssc_remote #(parameter int BC = 4) (
    input wire logic mclk,
    input wire logic txLine,
    output logic rxLine,
    output logic [7:0] gotByte
);
    timeunit 1ns / 1ps;
    initial rxLine = 1'b1;
    // start bit, data lsb first, stop bit, then one idle bit
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 11; i++) begin
            rxLine <= 1'(({2'b11, b, 1'b0}) >> i);
            repeat (BC) @(posedge mclk);
        end
    endtask
    // mid-bit samples of each frame the block sends
    always begin
        @(negedge txLine);
        repeat (BC + BC / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            gotByte[i] = txLine;
            repeat (BC) @(posedge mclk);
        end
    end
endmodule
`default_nettype wire

/* File: ssc_top_tb_top.sv */
// self-checking bench of the serial status/control block with a remote line model
// assumes a 4-cycle bit time so that frames stay short
`default_nettype none
module ssc_top_tb_top import ssc_pkg::*; ;
    timeunit 1ns / 1ps;
    logic mclk = 1'b0, rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0, cpuIntMask = 1'b0;
    logic waitMode = 1'b1, haltMode = 1'b0, irqReq, wakeReq, rxLine, txLine, txLineEn;
    logic [1:0] regAddr = 2'h0;
    logic [7:0] regWrData = 8'h00, regRdData, gotByte;
    int n_mismatch = 0, compares = 0;
    localparam logic W = 1'b1, R = 1'b0;
    ssc_top #(.BIT_CYCLES(4)) u_ssc_top (.*);
    ssc_remote #(.BC(4)) u_ssc_remote (.mclk(mclk), .txLine(txLine), .rxLine(rxLine),
        .gotByte(gotByte));
    // free-running clock
    initial forever #2 mclk = ~mclk;
    // count and report one comparison
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) n_mismatch++;
        if (got !== exp) $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    endtask
    // one-cycle strobe; read data checked in the cycle after
    task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] v);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= v;
        {regWr, regRd} <= {w, !w};
        @(posedge mclk);
        {regWr, regRd} <= 2'b00;
        #1;
        if (!w) chk(regRdData, v);
    endtask
    // status read then data read with no gap, both answers checked
    task automatic rd2(input logic [7:0] st, input logic [7:0] dat);
        @(posedge mclk);
        regAddr <= ADDR_STATUS;
        regRd <= 1'b1;
        @(posedge mclk);
        regAddr <= ADDR_DATA;
        #1;
        chk(regRdData, st);
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        chk(regRdData, dat);
    endtask
    task automatic results();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_regs();
        acc(R, ADDR_STATUS, STATUS_RESET);
        acc(W, ADDR_STATUS, 8'h00);
        acc(R, ADDR_STATUS, STATUS_RESET);
        acc(W, ADDR_CTRL2, 8'h80);
        chk({6'h00, irqReq, wakeReq}, 8'h03);
        @(posedge mclk);
        cpuIntMask <= 1'b1;
        #1 chk({6'h00, irqReq, wakeReq}, 8'h00);
        @(posedge mclk);
        cpuIntMask <= 1'b0;
        acc(W, ADDR_CTRL2, 8'h00);
    endtask
    task automatic t_tx();
        acc(W, ADDR_CTRL2, 8'h08);
        repeat (60) @(posedge mclk);
        acc(R, ADDR_STATUS, 8'hC0);
        acc(W, ADDR_DATA, 8'hA5);
        acc(R, ADDR_STATUS, 8'h00);
        repeat (60) @(posedge mclk);
        chk(gotByte, 8'hA5);
        acc(R, ADDR_STATUS, 8'hC0);
    endtask
    task automatic t_rx();
        acc(W, ADDR_CTRL2, 8'h2C);
        u_ssc_remote.send(8'h96);
        chk({6'h00, irqReq, wakeReq}, 8'h03);
        rd2(8'hE0, 8'h96);
        acc(R, ADDR_STATUS, 8'hC0);
        u_ssc_remote.send(8'h11);
        u_ssc_remote.send(8'h22);
        acc(R, ADDR_STATUS, 8'hE8);
        acc(R, ADDR_DATA, 8'h11);
    endtask
    // nine-bit word: the remote's stop bit lands as an address-mark ninth bit
    task automatic t_nine();
        acc(W, ADDR_CTRL1, 8'h1D);
        acc(W, ADDR_CTRL2, 8'h2E);
        u_ssc_remote.send(8'h5A);
        rd2(8'hE1, 8'h5A);
        acc(R, ADDR_CTRL1, 8'h9D);
        acc(R, ADDR_CTRL2, 8'h2C);
        acc(R, ADDR_STATUS, 8'hC0);
        acc(W, ADDR_CTRL1, 8'h00);
    endtask
    // halt blocks the port and the request, wait gates wake, low power drops the pin
    task automatic t_halt();
        acc(W, ADDR_CTRL2, 8'hAC);
        chk({7'h00, txLineEn}, 8'h01);
        @(posedge mclk);
        haltMode <= 1'b1;
        acc(W, ADDR_CTRL2, 8'h00);
        chk({6'h00, irqReq, wakeReq}, 8'h00);
        @(posedge mclk);
        haltMode <= 1'b0;
        waitMode <= 1'b0;
        acc(R, ADDR_CTRL2, 8'hAC);
        chk({6'h00, irqReq, wakeReq}, 8'h02);
        acc(W, ADDR_CTRL1, 8'h20);
        chk({7'h00, txLineEn}, 8'h00);
    endtask
    // reset for three cycles, then the scenarios
    initial begin
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        t_regs();
        t_tx();
        t_rx();
        t_nine();
        t_halt();
        results();
    end
    // cut a hang short
    initial begin
        #20000;
        n_mismatch++;
        results();
    end
endmodule
`default_nettype wire
